// ---- core/fpk_front_panel.sv ----
/*
  Front panel annunciator and key navigation for a protective relay:
  conditions and keys arrive over classic Wishbone, lamps go out.
  Assumes a 125 MHz clock, synchronous active high reset, and a
  Wishbone master that holds each request until ack.
*/
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////
// Operation
// - Self-test lamp lit while any self-diagnostic fault is flagged.
// - Test lamp lit for forced outputs, factory mode or active simulation.
// - Diff-blocked lamp lit when enabled and harmonic restraint blocks.
// - Local lamp lit exactly while in local mode.
// - Message lamp lit when any element picked up, operated or latched.
// - De-energized lamp lit while energization inhibit reports de-energized.
// - Overload lamp lit when transformer overload element operated.
// - Load-limit lamp lit when derating enabled and factor below 0.96.
// - Group lamps steady when active, flashing while that group is edited.
// - Trip lamp lit when any trip-type output relay operated.
// - Alarm lamp lit when any alarm-type output relay operated.
// - Pickup lamp lit whenever any element has picked up.
// - Phase lamps lit when that phase involved in any element condition.
// - Ground lamp lit when ground involved in any element condition.
// - Setpoint key goes to next page, or back to last setpoint viewed.
// - Actual key goes to next page, or back to last actual viewed.
// - Escape restores original value mid-edit, else moves up a header.
// - Enter commits edit only with access; on sub-header, descends.
// - Value keys step and wrap numerics, toggle yes/no, advance lists.
// - Reset in local mode clears latched relays and ended latched targets.
// - Active target overrides display, flashes message lamp; next cycles.
// - Next with no targets lights every lamp for five seconds.
module fpk_front_panel (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  output logic      [18:0] lamps_o,
  output logic             relay_reset_o
);

  ////////////////////////////////////////////////////////////////////
  // Registers
  logic [fpk_pkg::C_W-1:0] cond;
  logic [27:0]             elem;
  logic [4:0]              grp;
  logic [15:0]             derate;
  logic [31:0]             edit_lim;
  logic [fpk_pkg::N_TGT-1:0] tgt_act;
  logic [fpk_pkg::N_TGT-1:0] tgt_latch;
  logic [fpk_pkg::N_TGT-1:0] tgt_cond;
  logic [2:0]              tgt_sel;
  fpk_pkg::fpk_dsp_e       dsp;
  logic [fpk_pkg::PAGE_W-1:0] sp_page;
  logic [fpk_pkg::PAGE_W-1:0] act_page;
  logic [3:0]              level;
  logic                    editing;
  logic [31:0]             orig_val;
  logic [31:0]             value;
  logic [31:0]             stored;
  logic [18:0]             lamps;
  logic                    key_go;
  fpk_pkg::fpk_key_e       key;
  logic                    flash;
  logic                    ltest;
  logic                    ltest_start;

  logic wr;
  logic rd_hit;
  logic acc;
  logic [31:0] rd_data;
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wr  = acc & wb_we_i & rd_hit & (wb_sel_i == 4'hf);

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = {editing, 31'h0};
    if (wb_adr_i == fpk_pkg::REG_COND) rd_data = {17'h0, cond};
    else if (wb_adr_i == fpk_pkg::REG_ELEM) rd_data = {4'h0, elem};
    else if (wb_adr_i == fpk_pkg::REG_GROUP) rd_data = {27'h0, grp};
    else if (wb_adr_i == fpk_pkg::REG_DERATE) rd_data = {16'h0, derate};
    else if (wb_adr_i == fpk_pkg::REG_KEY) rd_hit = 1'b1;
    else if (wb_adr_i == fpk_pkg::REG_NAV)
      rd_data = {20'h0, level, act_page, sp_page[1:0], dsp};
    else if (wb_adr_i == fpk_pkg::REG_TARGET)
      rd_data = {13'h0, tgt_sel, tgt_latch, tgt_act};
    else if (wb_adr_i == fpk_pkg::REG_LAMPS) rd_data = {13'h0, lamps};
    else if (wb_adr_i == fpk_pkg::REG_EDITVAL)
      rd_data = editing ? value : stored;
    else if (wb_adr_i == fpk_pkg::REG_EDITLIM) rd_data = edit_lim;
    else rd_hit = 1'b0;
  end

  // Bus answer: one cycle after the strobe, err for unmapped addresses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= acc & rd_hit;
      wb_err_o <= acc & ~rd_hit;
      if (acc) wb_dat_o <= rd_data;
    end
  end

  // Plain condition registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cond     <= '0;
      elem     <= '0;
      grp      <= '0;
      derate   <= 16'hffff;
      edit_lim <= '0;
    end else if (wr) begin
      if (wb_adr_i == fpk_pkg::REG_COND) cond <= wb_dat_i[fpk_pkg::C_W-1:0];
      else if (wb_adr_i == fpk_pkg::REG_ELEM) elem <= wb_dat_i[27:0];
      else if (wb_adr_i == fpk_pkg::REG_GROUP) grp <= wb_dat_i[4:0];
      else if (wb_adr_i == fpk_pkg::REG_DERATE) derate <= wb_dat_i[15:0];
      else if (wb_adr_i == fpk_pkg::REG_EDITLIM) edit_lim <= wb_dat_i;
    end
  end

  // Key press decode: one pulse per write of REG_KEY
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_go <= 1'b0;
      key    <= fpk_pkg::FPK_KEY_SETPOINT;
    end else begin
      key_go <= wr & (wb_adr_i == fpk_pkg::REG_KEY);
      if (wr & (wb_adr_i == fpk_pkg::REG_KEY))
        key <= fpk_pkg::fpk_key_e'(wb_dat_i[2:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Targets
  logic next_key;
  logic reset_key;
  assign next_key  = key_go & (key == fpk_pkg::FPK_KEY_NEXT);
  assign reset_key = key_go & (key == fpk_pkg::FPK_KEY_RESET)
                     & cond[fpk_pkg::C_LOCAL];
  assign ltest_start = next_key & (tgt_act == '0);

  // Target condition inputs are REG_TARGET writes: [7:0] condition,
  // [15:8] latching kind; the set from a live condition wins over reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tgt_cond  <= '0;
      tgt_latch <= '0;
    end else if (wr & (wb_adr_i == fpk_pkg::REG_TARGET)) begin
      tgt_cond  <= wb_dat_i[7:0];
      tgt_latch <= wb_dat_i[15:8];
    end
  end

  genvar t;
  generate
    for (t = 0; t < fpk_pkg::N_TGT; t++) begin : g_tgt
      always_ff @(posedge clk_i) begin
        if (rst_i) tgt_act[t] <= 1'b0;
        else if (tgt_cond[t]) tgt_act[t] <= 1'b1;
        else if (!tgt_latch[t]) tgt_act[t] <= 1'b0;
        else if (reset_key) tgt_act[t] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) tgt_sel <= '0;
    else if (next_key & (tgt_act != '0)) tgt_sel <= tgt_sel + 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) relay_reset_o <= 1'b0;
    else relay_reset_o <= reset_key;
  end

  ////////////////////////////////////////////////////////////////////
  // Navigation
  logic tgt_new;
  logic [fpk_pkg::N_TGT-1:0] tgt_prev;
  always_ff @(posedge clk_i) begin
    if (rst_i) tgt_prev <= '0;
    else tgt_prev <= tgt_act;
  end
  assign tgt_new = |(tgt_act & ~tgt_prev);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dsp      <= fpk_pkg::FPK_DSP_DEFAULT;
      sp_page  <= '0;
      act_page <= '0;
      level    <= '0;
    end else if (tgt_new) begin
      dsp <= fpk_pkg::FPK_DSP_TARGET;
    end else if (key_go) begin
      case (key)
        fpk_pkg::FPK_KEY_SETPOINT: begin
          if (dsp == fpk_pkg::FPK_DSP_SETPOINT) begin
            sp_page <= (sp_page == fpk_pkg::SP_PAGES - 1'b1) ? '0
                       : sp_page + 1'b1;
            level   <= '0;
          end
          dsp <= fpk_pkg::FPK_DSP_SETPOINT;
        end
        fpk_pkg::FPK_KEY_ACTUAL: begin
          if (dsp == fpk_pkg::FPK_DSP_ACTUAL) begin
            act_page <= (act_page == fpk_pkg::ACT_PAGES - 1'b1) ? '0
                        : act_page + 1'b1;
            level    <= '0;
          end
          dsp <= fpk_pkg::FPK_DSP_ACTUAL;
        end
        fpk_pkg::FPK_KEY_ESCAPE: begin
          if (!editing && level != '0) level <= level - 1'b1;
        end
        fpk_pkg::FPK_KEY_ENTER: begin
          if (!editing && level != 4'hf) level <= level + 1'b1;
        end
        fpk_pkg::FPK_KEY_NEXT: begin
          if (tgt_act != '0) dsp <= fpk_pkg::FPK_DSP_TARGET;
        end
        default: begin
          if (dsp == fpk_pkg::FPK_DSP_TARGET)
            dsp <= fpk_pkg::FPK_DSP_SETPOINT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Setpoint edit: edit_lim = {max[15:0], min[7:0], step[5:0], kind}
  logic [15:0] vmax;
  logic [7:0]  vmin;
  logic [5:0]  vstep;
  logic [1:0]  vkind;
  logic [31:0] up_v;
  logic [31:0] dn_v;
  assign vmax  = edit_lim[31:16];
  assign vmin  = edit_lim[15:8];
  assign vstep = edit_lim[7:2];
  assign vkind = edit_lim[1:0];

  always_comb begin
    up_v = value;
    dn_v = value;
    if (vkind == fpk_pkg::KIND_YN) begin
      up_v = {31'h0, ~value[0]};
      dn_v = {31'h0, ~value[0]};
    end else if (vkind == fpk_pkg::KIND_LIST) begin
      up_v = (value >= {16'h0, vmax}) ? {24'h0, vmin} : value + 1;
      dn_v = up_v;
    end else begin
      up_v = (value + {26'h0, vstep} > {16'h0, vmax}) ? {24'h0, vmin}
             : value + {26'h0, vstep};
      dn_v = (value < {24'h0, vmin} + {26'h0, vstep}) ? {16'h0, vmax}
             : value - {26'h0, vstep};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      editing  <= 1'b0;
      value    <= '0;
      orig_val <= '0;
      stored   <= '0;
    end else if (wr & (wb_adr_i == fpk_pkg::REG_EDITVAL)) begin
      editing  <= 1'b0;
      stored   <= wb_dat_i;
      value    <= wb_dat_i;
    end else if (key_go) begin
      case (key)
        fpk_pkg::FPK_KEY_VAL_UP: begin
          if (!editing) orig_val <= value;
          editing <= 1'b1;
          value   <= up_v;
        end
        fpk_pkg::FPK_KEY_VAL_DN: begin
          if (!editing) orig_val <= value;
          editing <= 1'b1;
          value   <= dn_v;
        end
        fpk_pkg::FPK_KEY_ESCAPE: begin
          if (editing) begin
            value   <= orig_val;
            editing <= 1'b0;
          end
        end
        fpk_pkg::FPK_KEY_ENTER: begin
          if (editing && cond[fpk_pkg::C_ACCESS_OK]) begin
            stored  <= value;
            editing <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Lamps
  logic any_pu;
  logic any_elem;
  logic sim_on;
  assign any_pu   = |elem[fpk_pkg::E_PU_LSB +: fpk_pkg::N_ELEM];
  assign any_elem = |elem[23:0];
  assign sim_on   = (cond[fpk_pkg::C_SIM_LSB +: 2] != fpk_pkg::SIM_OFF);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lamps <= '0;
    end else if (ltest) begin
      lamps <= '1;
    end else begin
      lamps[0] <= cond[fpk_pkg::C_SELFTEST];
      lamps[1] <= cond[fpk_pkg::C_FORCE_REL] | cond[fpk_pkg::C_FORCE_ANA]
                  | cond[fpk_pkg::C_FACTORY] | sim_on;
      lamps[2] <= cond[fpk_pkg::C_DIFF_EN] & cond[fpk_pkg::C_HARM_BLK];
      lamps[3] <= cond[fpk_pkg::C_LOCAL];
      lamps[4] <= (tgt_act != '0) ? flash : any_elem;
      lamps[5] <= cond[fpk_pkg::C_DEENERG];
      lamps[6] <= cond[fpk_pkg::C_XF_OVLD];
      lamps[7] <= cond[fpk_pkg::C_DERATE_EN]
                  & (derate < fpk_pkg::DERATE_THRESH);
      for (int g = 0; g < fpk_pkg::N_GROUP; g++) begin
        if (grp[4] && grp[3:2] == g[1:0])
          lamps[8 + g] <= flash;
        else
          lamps[8 + g] <= (grp[1:0] == g[1:0]);
      end
      lamps[12] <= cond[fpk_pkg::C_TRIP_OP];
      lamps[13] <= cond[fpk_pkg::C_ALARM_OP];
      lamps[14] <= any_pu;
      lamps[17:15] <= any_elem ? elem[26:24] : 3'h0;
      lamps[18] <= any_elem & elem[27];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) lamps_o <= '0;
    else lamps_o <= lamps;
  end

  fpk_flash u_flash (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .flash_o (flash)
  );

  fpk_lamp_test u_ltest (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (ltest_start),
    .active_o (ltest)
  );

endmodule

// ---- core/fpk_pkg.sv ----
/*
  Constants and enumerations of the front panel indicator and key block.
  Assumes a 125 MHz system clock and a 32-bit classic Wishbone bus.
*/
package fpk_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ           = 125_000_000;
  localparam int unsigned LAMP_TEST_MS     = 5000;
  localparam int unsigned LAMP_TEST_CYCLES =
    (CLK_HZ / 1000) * LAMP_TEST_MS;
  localparam int unsigned FLASH_HALF_MS     = 250;
  localparam int unsigned FLASH_HALF_CYCLES =
    (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int unsigned CNT_W = 32;

  // Register byte offsets
  localparam logic [7:0] REG_COND    = 8'h00;
  localparam logic [7:0] REG_ELEM    = 8'h04;
  localparam logic [7:0] REG_GROUP   = 8'h08;
  localparam logic [7:0] REG_DERATE  = 8'h0c;
  localparam logic [7:0] REG_KEY     = 8'h10;
  localparam logic [7:0] REG_NAV     = 8'h14;
  localparam logic [7:0] REG_TARGET  = 8'h18;
  localparam logic [7:0] REG_LAMPS   = 8'h1c;
  localparam logic [7:0] REG_EDITVAL = 8'h20;
  localparam logic [7:0] REG_EDITLIM = 8'h24;

  // REG_COND bit positions
  localparam int unsigned C_SELFTEST   = 0;
  localparam int unsigned C_FORCE_REL  = 1;
  localparam int unsigned C_FORCE_ANA  = 2;
  localparam int unsigned C_FACTORY    = 3;
  localparam int unsigned C_SIM_LSB    = 4;
  localparam int unsigned C_DIFF_EN    = 6;
  localparam int unsigned C_HARM_BLK   = 7;
  localparam int unsigned C_LOCAL      = 8;
  localparam int unsigned C_DEENERG    = 9;
  localparam int unsigned C_XF_OVLD    = 10;
  localparam int unsigned C_DERATE_EN  = 11;
  localparam int unsigned C_TRIP_OP    = 12;
  localparam int unsigned C_ALARM_OP   = 13;
  localparam int unsigned C_ACCESS_OK  = 14;
  localparam int unsigned C_W          = 15;

  // REG_ELEM: [7:0] pickup, [15:8] operated, [23:16] latched,
  // [27:24] phase A,B,C,ground involvement
  localparam int unsigned N_ELEM = 8;
  localparam int unsigned E_PU_LSB  = 0;
  localparam int unsigned E_OP_LSB  = 8;
  localparam int unsigned E_LT_LSB  = 16;
  localparam int unsigned E_PH_LSB  = 24;

  // Simulation function codes
  localparam logic [1:0] SIM_OFF = 2'h0;

  // Derating threshold 0.96 in unsigned 0.16 fixed point
  localparam logic [15:0] DERATE_THRESH = 16'hf5c3;

  // Setpoint group field: [1:0] active, [3:2] edited, [4] editing
  localparam int unsigned N_GROUP = 4;

  // Key codes written to REG_KEY
  typedef enum logic [2:0] {
    FPK_KEY_SETPOINT = 3'b000,
    FPK_KEY_ACTUAL   = 3'b001,
    FPK_KEY_ESCAPE   = 3'b010,
    FPK_KEY_ENTER    = 3'b011,
    FPK_KEY_VAL_UP   = 3'b100,
    FPK_KEY_VAL_DN   = 3'b101,
    FPK_KEY_RESET    = 3'b110,
    FPK_KEY_NEXT     = 3'b111
  } fpk_key_e;

  // Display context
  typedef enum logic [1:0] {
    FPK_DSP_DEFAULT  = 2'b00,
    FPK_DSP_SETPOINT = 2'b01,
    FPK_DSP_ACTUAL   = 2'b10,
    FPK_DSP_TARGET   = 2'b11
  } fpk_dsp_e;

  // Setpoint kind for value keys
  localparam logic [1:0] KIND_NUM  = 2'h0;
  localparam logic [1:0] KIND_YN   = 2'h1;
  localparam logic [1:0] KIND_LIST = 2'h2;

  localparam int unsigned PAGE_W  = 4;
  localparam logic [PAGE_W-1:0] SP_PAGES  = 4'h6;
  localparam logic [PAGE_W-1:0] ACT_PAGES = 4'h5;
  localparam int unsigned N_TGT = 8;

endpackage

// ---- core/fpk_flash.sv ----
/*
  Flash timebase: a free running square wave with equal on and off time.
  Assumes the system clock and synchronous active high reset.
*/
`timescale 1ns/10ps
module fpk_flash #(
  parameter int unsigned HALF_CYCLES = fpk_pkg::FLASH_HALF_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      flash_o
);

  logic [fpk_pkg::CNT_W-1:0] cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt     <= '0;
      flash_o <= 1'b0;
    end else if (cnt == HALF_CYCLES[fpk_pkg::CNT_W-1:0] - 1'b1) begin
      cnt     <= '0;
      flash_o <= ~flash_o;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule

// ---- core/fpk_lamp_test.sv ----
/*
  Lamp test timer: holds active for a fixed count after a start pulse.
  Assumes the system clock and synchronous active high reset.
*/
`timescale 1ns/10ps
module fpk_lamp_test #(
  parameter int unsigned TEST_CYCLES = fpk_pkg::LAMP_TEST_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      active_o
);

  logic [fpk_pkg::CNT_W-1:0] cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt      <= '0;
      active_o <= 1'b0;
    end else if (start_i) begin
      cnt      <= TEST_CYCLES[fpk_pkg::CNT_W-1:0] - 1'b1;
      active_o <= 1'b1;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end else begin
      active_o <= 1'b0;
    end
  end

endmodule

// ---- bench/fpk_operator.sv ----
/* Operator model: the person at the keys, as a classic Wishbone
   master of single cycles. Assumes each request gets ack or err. */
`timescale 1ns/10ps
module fpk_operator (
  input  wire logic        clk_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  output logic      [7:0]  adr_o,
  output logic      [31:0] dat_o,
  output logic      [3:0]  sel_o,
  output logic             we_o,
  output logic             cyc_o
);
  initial begin
    adr_o = 8'h0;
    dat_o = 32'h0;
    sel_o = 4'h0;
    we_o  = 1'b0;
    cyc_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////
  // Held until ack or err is sampled; released lines show junk
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q, output logic e);
    adr_o <= a;
    we_o  <= w;
    dat_o <= d;
    sel_o <= s;
    cyc_o <= 1'b1;
    @(posedge clk_i);
    while (!(ack_i || err_i)) @(posedge clk_i);
    q = dat_i;
    e = err_i;
    cyc_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule

// ---- bench/fpk_front_panel_chk.sv ----
/* Checker: lamps against stored conditions, reset key, bus answer.
   Sees only the top module's ports. */
`timescale 1ns/10ps
module fpk_front_panel_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic [18:0] lamps_o,
  input wire logic        relay_reset_o
);
  logic [31:0] cnd, elm;
  logic [2:0]  st;
  logic        wdn, ok, kr;
  assign wdn = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & (&wb_sel_i);
  assign ok  = (st == 3'h7) && (lamps_o != 19'h7ffff);
  assign kr  = wdn && (wb_adr_i == fpk_pkg::REG_KEY)
               && (wb_dat_i[2:0] == 3'h6);
  // Shadow of what software last stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnd <= 32'h0;
      elm <= 32'h0;
    end else if (wdn && wb_adr_i == fpk_pkg::REG_COND) begin
      cnd <= wb_dat_i;
    end else if (wdn && wb_adr_i == fpk_pkg::REG_ELEM) begin
      elm <= wb_dat_i;
    end
  end
  // Cycles since the last stored write, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || wdn) st <= 3'h0;
    else if (st != 3'h7) st <= st + 3'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////
  property p_st; ok |-> lamps_o[0] == cnd[0]; endproperty
  a_st: assert property (p_st) else $error("selftest lamp");
  property p_tm; ok |-> lamps_o[1] == (|cnd[5:1]); endproperty
  a_tm: assert property (p_tm) else $error("test lamp");
  property p_db; ok |-> lamps_o[2] == (cnd[6] & cnd[7]); endproperty
  a_db: assert property (p_db) else $error("diff lamp");
  property p_lc; ok |-> lamps_o[3] == cnd[8]; endproperty
  a_lc: assert property (p_lc) else $error("local lamp");
  property p_de; ok |-> lamps_o[6:5] == cnd[10:9]; endproperty
  a_de: assert property (p_de) else $error("xfmr lamps");
  property p_ta; ok |-> lamps_o[13:12] == cnd[13:12]; endproperty
  a_ta: assert property (p_ta) else $error("trip alarm");
  property p_pu; ok |-> lamps_o[14] == (|elm[7:0]); endproperty
  a_pu: assert property (p_pu) else $error("pickup lamp");
  property p_ph;
    ok |-> lamps_o[18:15] == (elm[27:24] & {4{|elm[23:0]}});
  endproperty
  a_ph: assert property (p_ph) else $error("phase lamps");
  property p_rr; kr && cnd[8] |-> ##[0:2] relay_reset_o; endproperty
  a_rr: assert property (p_rr) else $error("no relay reset");
  property p_nr; kr && !cnd[8] |=> !relay_reset_o [*3]; endproperty
  a_nr: assert property (p_nr) else $error("remote reset");
  property p_ak;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o;
  endproperty
  a_ak: assert property (p_ak) else $error("bus answer late");
endmodule

bind fpk_front_panel fpk_front_panel_chk i_fpk_front_panel_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .lamps_o(lamps_o),
  .relay_reset_o(relay_reset_o));

// ---- bench/test_fpk_front_panel.sv ----
/* Testbench: drives conditions and key presses through the operator
   model and judges lamps and registers. Needs fpk_pkg and the design. */
`timescale 1ns/10ps
module test_fpk_front_panel;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc, we, ack, err, rrst, e;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wd, rdat, q;
  logic [18:0] lamps;
  int          mismatches = 0;
  int          n_compared = 0;
  logic [15:0] cv [16] = '{1, 2, 4, 8, 'h10, 'h20, 'h30, 'h40, 'h80,
                           'hc0, 'h100, 'h200, 'h400, 'h800, 'h1000, 'h2000};
  logic [15:0] lv [16] = '{1, 2, 2, 2, 2, 2, 2, 0, 0, 4, 8, 'h20, 'h40,
                           0, 'h1000, 'h2000};
  logic [31:0] ev [4] = '{'h05000001, 'h0a000100, 'h01010000, 'h0f000000};
  logic [18:0] el [4] = '{'h2c110, 'h50110, 'h08110, 'h00100};

  always #4 clk = ~clk;

  fpk_operator i_fpk_operator (.clk_i(clk), .dat_i(rdat), .ack_i(ack),
    .err_i(err), .adr_o(adr), .dat_o(wd), .sel_o(sel), .we_o(we),
    .cyc_o(cyc));
  fpk_front_panel i_fpk_front_panel (.clk_i(clk), .rst_i(rst),
    .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .lamps_o(lamps), .relay_reset_o(rrst));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] x, g);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_fpk_operator.bus(a, 1'b1, d, 4'hf, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    i_fpk_operator.bus(a, 1'b0, 32'h0, 4'hf, q, e);
  endtask
  task automatic key(input fpk_pkg::fpk_key_e k);
    wr(fpk_pkg::REG_KEY, 32'(k));
    repeat (3) @(posedge clk);
  endtask
  task automatic nav(input fpk_pkg::fpk_key_e k);
    key(k);
    rd(fpk_pkg::REG_NAV);
  endtask
  task automatic val(input fpk_pkg::fpk_key_e k, input logic [31:0] x);
    key(k);
    rd(fpk_pkg::REG_EDITVAL);
    chk("edit value", x, q);
  endtask
  task automatic lk(input string n, input logic [18:0] x);
    repeat (4) @(posedge clk);
    chk(n, 32'(x), 32'(lamps));
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_bus;
    rd(8'h40);
    chk("unmapped err", 32'h1, 32'(e));
    i_fpk_operator.bus(fpk_pkg::REG_COND, 1'b1, 32'h1, 4'h1, q, e);
    lk("partial sel", 19'h100);
    $display("done bus");
  endtask
  task automatic t_cond;
    for (int i = 0; i < 16; i++) begin
      wr(fpk_pkg::REG_COND, 32'(cv[i]));
      lk("cond lamps", 19'(lv[i] | 16'h100));
    end
    wr(fpk_pkg::REG_COND, 32'h800);
    wr(fpk_pkg::REG_DERATE, 32'hf5c2);
    lk("derate low", 19'h180);
    wr(fpk_pkg::REG_DERATE, 32'hf5c3);
    lk("derate at", 19'h100);
    wr(fpk_pkg::REG_DERATE, 32'hf5c2);
    wr(fpk_pkg::REG_COND, 32'h0);
    lk("derate off", 19'h100);
    $display("done cond");
  endtask
  task automatic t_elem;
    for (int i = 0; i < 4; i++) begin
      wr(fpk_pkg::REG_ELEM, ev[i]);
      lk("elem lamps", el[i]);
    end
    for (int g = 0; g < 4; g++) begin
      wr(fpk_pkg::REG_GROUP, 32'(g));
      lk("group lamp", 19'h100 << g);
    end
    wr(fpk_pkg::REG_GROUP, 32'h15);
    lk("group edit", 19'h0);
    wr(fpk_pkg::REG_GROUP, 32'h0);
    $display("done elem");
  endtask
  task automatic t_nav;
    logic [31:0] a0, s0;
    rd(fpk_pkg::REG_NAV);
    chk("display idle", 32'h0, 32'(q[1:0]));
    nav(fpk_pkg::FPK_KEY_SETPOINT);
    s0 = q;
    chk("display sp", 32'h1, 32'(q[1:0]));
    nav(fpk_pkg::FPK_KEY_ACTUAL);
    chk("display act", 32'h2, 32'(q[1:0]));
    a0 = 32'((q[7:4] + 4'h1) % fpk_pkg::ACT_PAGES);
    nav(fpk_pkg::FPK_KEY_ACTUAL);
    chk("act page", a0, 32'(q[7:4]));
    nav(fpk_pkg::FPK_KEY_SETPOINT);
    chk("sp return", 32'({s0[3:2], 2'h1}), 32'(q[3:0]));
    nav(fpk_pkg::FPK_KEY_SETPOINT);
    chk("sp next", 32'(s0[3:2] + 2'h1), 32'(q[3:2]));
    nav(fpk_pkg::FPK_KEY_ACTUAL);
    chk("act return", {a0[3:0], 2'h2}, 32'({q[7:4], q[1:0]}));
    $display("done nav");
  endtask
  task automatic t_edit;
    nav(fpk_pkg::FPK_KEY_SETPOINT);
    wr(fpk_pkg::REG_EDITLIM, {16'd10, 8'd2, 6'd4, 2'd0});
    wr(fpk_pkg::REG_EDITVAL, 32'd6);
    val(fpk_pkg::FPK_KEY_VAL_UP, 32'd10);
    val(fpk_pkg::FPK_KEY_VAL_UP, 32'd2);
    val(fpk_pkg::FPK_KEY_VAL_DN, 32'd10);
    val(fpk_pkg::FPK_KEY_ESCAPE, 32'd6);
    key(fpk_pkg::FPK_KEY_VAL_UP);
    key(fpk_pkg::FPK_KEY_ENTER);
    val(fpk_pkg::FPK_KEY_ESCAPE, 32'd6);
    wr(fpk_pkg::REG_COND, 32'h4000);
    key(fpk_pkg::FPK_KEY_VAL_UP);
    val(fpk_pkg::FPK_KEY_ENTER, 32'd10);
    wr(fpk_pkg::REG_EDITLIM, {16'd1, 8'd0, 6'd1, 2'd1});
    wr(fpk_pkg::REG_EDITVAL, 32'd0);
    val(fpk_pkg::FPK_KEY_VAL_UP, 32'd1);
    key(fpk_pkg::FPK_KEY_ESCAPE);
    wr(fpk_pkg::REG_EDITLIM, {16'd3, 8'd0, 6'd1, 2'd2});
    wr(fpk_pkg::REG_EDITVAL, 32'd1);
    val(fpk_pkg::FPK_KEY_VAL_UP, 32'd2);
    key(fpk_pkg::FPK_KEY_ESCAPE);
    $display("done edit");
  endtask
  task automatic t_target;
    logic [2:0] s;
    wr(fpk_pkg::REG_COND, 32'h0);
    wr(fpk_pkg::REG_TARGET, 32'h5);
    rd(fpk_pkg::REG_NAV);
    chk("target view", 32'h3, 32'(q[1:0]));
    rd(fpk_pkg::REG_TARGET);
    s = q[18:16];
    chk("active", 32'h5, 32'(q[7:0]));
    key(fpk_pkg::FPK_KEY_NEXT);
    rd(fpk_pkg::REG_TARGET);
    chk("next moves", 32'(s + 3'h1), 32'(q[18:16]));
    wr(fpk_pkg::REG_TARGET, 32'h0);
    rd(fpk_pkg::REG_TARGET);
    chk("self reset", 32'h0, 32'(q[7:0]));
    wr(fpk_pkg::REG_TARGET, 32'h202);
    wr(fpk_pkg::REG_TARGET, 32'h200);
    key(fpk_pkg::FPK_KEY_RESET);
    rd(fpk_pkg::REG_TARGET);
    chk("remote reset", 32'h2, 32'(q[7:0]));
    wr(fpk_pkg::REG_COND, 32'h100);
    key(fpk_pkg::FPK_KEY_RESET);
    rd(fpk_pkg::REG_TARGET);
    chk("local reset", 32'h0, 32'(q[7:0]));
    wr(fpk_pkg::REG_TARGET, 32'h0);
    wr(fpk_pkg::REG_COND, 32'h0);
    key(fpk_pkg::FPK_KEY_NEXT);
    lk("lamp test", 19'h7ffff);
    $display("done target");
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_bus();
    t_cond();
    t_elem();
    t_nav();
    t_edit();
    t_target();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
